//--- rtl/async_serial_port_control.sv
// Asynchronous serial port with five byte registers over AXI4-Lite
// Assumes one 10 MHz clock, a synchronous active-low reset and an async rxd pin
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "serial_port_regs.svh"

module async_serial_port_control
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line
  input wire logic rxd,
  output tx_pin_s tx_pin,
  // Serial interrupt
  output logic serial_irq
);

  // ==========================================
  // Register storage
  logic [7:0] ctl_q;
  logic [7:0] rate_q;
  logic len9_q, wake_q, tx9_q, rx9_q;
  logic [7:0] tx_holding_reg_q, rx_holding_reg_q;
  logic tx_holding_empty_q, tx_complete_flag_q;
  rx_flags_s rxf_q;
  logic status_seen_q;

  // Prescale lookup for the two-bit field
  function automatic logic [4:0] base_division(input logic [1:0] code);
    unique case (code)
      2'h0: base_division = `PRESCALE_1;
      2'h1: base_division = `PRESCALE_3;
      2'h2: base_division = `PRESCALE_4;
      2'h3: base_division = `PRESCALE_13;
    endcase
  endfunction

  // Oversample tick period: prescale times two to the divisor field
  function automatic logic [11:0] tick_period(input logic [1:0] p, input logic [2:0] d);
    tick_period = 12'(base_division(p)) << d;
  endfunction

  // ==========================================
  // AXI4-Lite slave
  logic aw_q, w_q, ar_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic wr_fire, rd_fire, wr_data_port, rd_data_port, rd_status;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !ar_q && !s_axi_rvalid;
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;
  assign rd_fire = ar_q && !s_axi_rvalid;
  assign wr_data_port = wr_fire && s_axi_wdata_ok(awaddr_q, `OFS_DATA_PORT) && wdata_q[31];
  assign rd_data_port = rd_fire && s_axi_wdata_ok(araddr_q, `OFS_DATA_PORT);
  assign rd_status = rd_fire && s_axi_wdata_ok(araddr_q, `OFS_STATUS_FLAGS);

  // Address match on a word-aligned byte address
  function automatic logic s_axi_wdata_ok(input logic [7:0] a, input logic [7:0] ofs);
    s_axi_wdata_ok = (a[7:2] == ofs[5:0]) && (a[1:0] == 2'h0);
  endfunction

  // Capture address and data channels in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        // Low byte lane must be strobed; bit 31 marks a real byte write
        wdata_q <= {s_axi_wstrb[0], 23'h000000, s_axi_wdata[7:0]};
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q[7:2] >= `OFS_STATUS_FLAGS && awaddr_q[7:2] <=
                      `OFS_IRQ_ENABLE_CONTROL && awaddr_q[1:0] == 2'h0) ? `RESP_OKAY
                      : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= 1'b0;
      araddr_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= 1'b1;
      araddr_q <= s_axi_araddr;
    end else if (rd_fire) begin
      ar_q <= 1'b0;
    end
  end

  // Read data mux; reserved frame bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      unique case (araddr_q)
        (`OFS_STATUS_FLAGS << `ADDR_SHIFT): s_axi_rdata <= {24'h000000, tx_holding_empty_q,
          tx_complete_flag_q, rxf_q, 1'b0};
        (`OFS_DATA_PORT << `ADDR_SHIFT): s_axi_rdata <= {24'h000000, rx_holding_reg_q};
        (`OFS_RATE_SETTING << `ADDR_SHIFT): s_axi_rdata <= {24'h000000, rate_q};
        (`OFS_FRAME_CONFIG << `ADDR_SHIFT): s_axi_rdata <= {24'h000000, rx9_q, tx9_q, 1'b0,
          len9_q, wake_q, 3'h0};
        (`OFS_IRQ_ENABLE_CONTROL << `ADDR_SHIFT): s_axi_rdata <= {24'h000000, ctl_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Control registers
  logic wake_hit;
  logic ctl_wr;
  assign ctl_wr = wr_fire && wdata_q[31] && s_axi_wdata_ok(awaddr_q, `OFS_IRQ_ENABLE_CONTROL);

  // Interrupt and enable control; hardware clears mute on wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= `RST_IRQ_ENABLE_CONTROL;
    end else begin
      if (ctl_wr) begin
        ctl_q <= wdata_q[7:0];
      end
      if (wake_hit) begin
        ctl_q[`IE_MUTE] <= 1'b0;
      end
    end
  end

  // Rate and frame configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_q <= {`RST_RATE_PRESCALE, 6'h00};
      len9_q <= 1'b0;
      wake_q <= 1'b0;
      tx9_q <= 1'b0;
    end else if (wr_fire && wdata_q[31]) begin
      if (s_axi_wdata_ok(awaddr_q, `OFS_RATE_SETTING)) begin
        rate_q <= wdata_q[7:0];
      end
      if (s_axi_wdata_ok(awaddr_q, `OFS_FRAME_CONFIG)) begin
        tx9_q <= wdata_q[`FC_TX9];
        len9_q <= wdata_q[`FC_LEN9];
        wake_q <= wdata_q[`FC_WAKE];
      end
    end
  end

  // Status read arms the clearing sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_seen_q <= 1'b0;
    end else if (rd_status) begin
      status_seen_q <= 1'b1;
    end else if (rd_data_port || wr_data_port) begin
      status_seen_q <= 1'b0;
    end
  end

  // ==========================================
  // Rate dividers: one oversample tick per period, 32 ticks per bit
  logic [11:0] tx_div_q, rx_div_q;
  logic tx_tick, rx_tick;
  tx_state_e tx_state_q;
  assign tx_tick = (tx_div_q == 12'h000);
  assign rx_tick = (rx_div_q == 12'h000);

  // Transmit divider restarts while idle so every start bit is a full bit time
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_tick || tx_state_q == TX_IDLE) begin
      tx_div_q <= tick_period(rate_q[7:6], rate_q[5:3]) - 12'h001;
    end else begin
      tx_div_q <= tx_div_q - 12'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_tick) begin
      rx_div_q <= tick_period(rate_q[7:6], rate_q[2:0]) - 12'h001;
    end else begin
      rx_div_q <= rx_div_q - 12'h001;
    end
  end

  // ==========================================
  // Transmitter
  logic [10:0] tx_shift_q;
  logic [3:0] tx_bits_q;
  logic [4:0] tx_sub_q;
  logic te_prev_q, brk_prev_q, pre_pend_q, brk_pend_q;
  logic tx_load, tx_bit_end;
  logic [3:0] frame_bits;
  assign frame_bits = len9_q ? 4'hB : 4'hA;
  assign tx_bit_end = tx_tick && (tx_sub_q == 5'h1F);
  assign tx_load = (tx_state_q == TX_IDLE) && ctl_q[`IE_TE];

  // Pending preamble and break requests from enable or break pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      te_prev_q <= 1'b0;
      brk_prev_q <= 1'b0;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      te_prev_q <= ctl_q[`IE_TE];
      brk_prev_q <= ctl_q[`IE_BRK];
      if (!te_prev_q && ctl_q[`IE_TE] && tx_state_q == TX_SHIFT) begin
        pre_pend_q <= 1'b1;
      end else if (tx_load && !ctl_q[`IE_BRK] && !brk_pend_q) begin
        pre_pend_q <= 1'b0;
      end
      if (brk_prev_q && !ctl_q[`IE_BRK]) begin
        brk_pend_q <= 1'b1;
      end else if (tx_load) begin
        brk_pend_q <= 1'b0;
      end
    end
  end

  // Shifter: break first, then preamble, then data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_sub_q <= 5'h00;
    end else if (tx_load && (ctl_q[`IE_BRK] || brk_pend_q)) begin
      tx_shift_q <= 11'h000;
      tx_state_q <= TX_SHIFT;
      tx_bits_q <= frame_bits;
      tx_sub_q <= 5'h00;
    end else if (tx_load && pre_pend_q) begin
      tx_shift_q <= 11'h7FF;
      tx_state_q <= TX_SHIFT;
      tx_bits_q <= frame_bits;
      tx_sub_q <= 5'h00;
    end else if (tx_load && !tx_holding_empty_q) begin
      tx_shift_q <= len9_q ? {1'b1, tx9_q, tx_holding_reg_q, 1'b0}
                           : {2'h3, tx_holding_reg_q, 1'b0};
      tx_state_q <= TX_SHIFT;
      tx_bits_q <= frame_bits;
      tx_sub_q <= 5'h00;
    end else if (tx_state_q == TX_SHIFT && tx_tick) begin
      tx_sub_q <= tx_sub_q + 5'h01;
      if (tx_bit_end) begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        if (tx_bits_q == 4'h1) begin
          tx_state_q <= TX_IDLE;
        end
      end
    end
  end

  // Transmit holding register and its flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding_reg_q <= 8'h00;
      tx_holding_empty_q <= 1'(`RST_STATUS_FLAGS >> 7);
      tx_complete_flag_q <= 1'(`RST_STATUS_FLAGS >> 6);
    end else begin
      if (wr_data_port) begin
        tx_holding_reg_q <= wdata_q[7:0];
        if (status_seen_q) begin
          tx_holding_empty_q <= 1'b0;
          tx_complete_flag_q <= 1'b0;
        end
      end
      if (tx_load && !ctl_q[`IE_BRK] && !brk_pend_q && !pre_pend_q && !tx_holding_empty_q) begin
        tx_holding_empty_q <= 1'b1;
      end
      if (tx_state_q == TX_SHIFT && tx_bit_end && tx_bits_q == 4'h1) begin
        tx_complete_flag_q <= 1'b1;
      end
    end
  end

  // Pin handed to the port while enabled or still shifting; enable is active low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin <= '{txd: 1'b1, txd_en: 1'b1};
    end else begin
      tx_pin.txd <= tx_shift_q[0];
      tx_pin.txd_en <= !(ctl_q[`IE_TE] || tx_state_q == TX_SHIFT);
    end
  end

  // ==========================================
  // Receiver: three-stage pin synchroniser
  logic [2:0] rx_sync_q;
  logic rx_level_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync_q <= 3'h7;
      rx_level_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rxd};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_level_q <= rx_sync_q[2];
      end
    end
  end

  rx_state_e rx_state_q;
  logic [9:0] rx_shift_q;
  logic [3:0] rx_bits_q;
  logic [4:0] rx_sub_q;
  logic [2:0] rx_votes_q;
  logic rx_noise_q;
  logic [3:0] rx_ones_q;
  logic idle_armed_q;
  logic rx_done, rx_bit, rx_addr_mark, idle_line;
  assign rx_bit = (rx_votes_q[0] & rx_votes_q[1]) | (rx_votes_q[1] & rx_level_q)
                  | (rx_votes_q[0] & rx_level_q);
  assign rx_done = rx_state_q == RX_SHIFT && rx_tick && rx_sub_q == `SAMPLE_NOISE_B
                   && rx_bits_q == 4'h1;
  assign rx_addr_mark = rx_shift_q[9]; // Most significant data bit in either length
  assign idle_line = rx_tick && rx_state_q == RX_HUNT && rx_sub_q == 5'h1F
                     && rx_ones_q == frame_bits;
  assign wake_hit = ctl_q[`IE_MUTE] && ((rx_done && wake_q && rx_addr_mark)
                    || (idle_line && !wake_q));

  // Start hunt, three-vote sampling of each bit and idle counting
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl_q[`IE_RE]) begin
      rx_state_q <= RX_HUNT;
      rx_shift_q <= 10'h000;
      rx_bits_q <= 4'h0;
      rx_sub_q <= 5'h00;
      rx_votes_q <= 3'h0;
      rx_noise_q <= 1'b0;
      rx_ones_q <= 4'h0;
    end else if (rx_tick) begin
      rx_sub_q <= rx_sub_q + 5'h01;
      unique case (rx_state_q)
        RX_HUNT: begin
          if (!rx_level_q) begin
            rx_state_q <= RX_SHIFT;
            rx_sub_q <= 5'h01;
            rx_bits_q <= frame_bits;
            rx_noise_q <= 1'b0;
            rx_ones_q <= 4'h0;
          end else if (rx_sub_q == 5'h1F && rx_ones_q != frame_bits) begin
            rx_ones_q <= rx_ones_q + 4'h1;
          end
        end
        RX_SHIFT: begin
          if (rx_sub_q == `SAMPLE_NOISE_A) rx_votes_q[0] <= rx_level_q;
          if (rx_sub_q == `HALF_SAMPLE) rx_votes_q[1] <= rx_level_q;
          if (rx_sub_q == `SAMPLE_NOISE_B) begin
            rx_noise_q <= rx_noise_q | (rx_votes_q[0] != rx_level_q)
                          | (rx_votes_q[1] != rx_level_q);
            rx_shift_q <= {rx_bit, rx_shift_q[9:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h1) begin
              rx_state_q <= RX_HUNT;
              rx_sub_q <= 5'h00;
            end
          end
          if (rx_sub_q == 5'h1F) rx_sub_q <= 5'h00;
        end
      endcase
    end
  end

  // Receive holding register, ninth bit and flags
  logic rx_clear;
  assign rx_clear = rd_data_port && status_seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_holding_reg_q <= 8'h00;
      rx9_q <= 1'b0;
      rxf_q <= '0;
      idle_armed_q <= 1'b1;
    end else if (!ctl_q[`IE_RE]) begin
      rxf_q <= '0;
      idle_armed_q <= 1'b1;
    end else begin
      if (rx_clear) begin
        rxf_q <= '0;
      end
      if (idle_line && !ctl_q[`IE_MUTE] && idle_armed_q) begin
        rxf_q.idle <= 1'b1;
        idle_armed_q <= 1'b0;
      end
      if (rx_done && (!ctl_q[`IE_MUTE] || wake_hit)) begin
        idle_armed_q <= 1'b1;
        if (rxf_q.full && !rx_clear) begin
          rxf_q.overrun <= 1'b1;
        end else begin
          rx_holding_reg_q <= len9_q ? rx_shift_q[8:1] : rx_shift_q[9:2];
          rx9_q <= rx_shift_q[9];
          rxf_q.full <= 1'b1;
          rxf_q.noise <= rx_noise_q;
          rxf_q.framing <= !rx_bit;
        end
      end
    end
  end

  // ==========================================
  // Serial interrupt from enabled flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= (ctl_q[`IE_TXE] && tx_holding_empty_q)
                    || (ctl_q[`IE_TXD] && tx_complete_flag_q)
                    || (ctl_q[`IE_RX] && (rxf_q.overrun || rxf_q.full))
                    || (ctl_q[`IE_IDLE] && rxf_q.idle);
    end
  end

endmodule

//--- include/serial_port_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data words
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// ==========================================
// Register word offsets
`define OFS_STATUS_FLAGS 8'h30
`define OFS_DATA_PORT 8'h31
`define OFS_RATE_SETTING 8'h32
`define OFS_FRAME_CONFIG 8'h33
`define OFS_IRQ_ENABLE_CONTROL 8'h34
// Byte address is four times the printed offset
`define ADDR_SHIFT 2

// ==========================================
// Reset values
`define RST_STATUS_FLAGS 8'hC0
`define RST_IRQ_ENABLE_CONTROL 8'h00
`define RST_RATE_PRESCALE 2'h0

// ==========================================
// Field positions
`define FC_RX9 7
`define FC_TX9 6
`define FC_LEN9 4
`define FC_WAKE 3
`define IE_TXE 7
`define IE_TXD 6
`define IE_RX 5
`define IE_IDLE 4
`define IE_TE 3
`define IE_RE 2
`define IE_MUTE 1
`define IE_BRK 0

// ==========================================
// Rate generation
`define OVERSAMPLE 6'h20
`define HALF_SAMPLE 5'h10
`define SAMPLE_NOISE_A 5'h0E
`define SAMPLE_NOISE_B 5'h12
`define PRESCALE_1 5'h01
`define PRESCALE_3 5'h03
`define PRESCALE_4 5'h04
`define PRESCALE_13 5'h0D

// ==========================================
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- include/serial_port_pkg.sv
// Types shared by the serial port design
// Assumes the register header is included alongside
package serial_port_pkg;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_SHIFT
  } rx_state_e;

  // Receive status flags as they sit in status bits 5..1
  typedef struct packed {
    logic full;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
  } rx_flags_s;

  // Serial pin pair
  typedef struct packed {
    logic txd;
    logic txd_en;
  } tx_pin_s;

endpackage

//--- dv/serial_far_end.sv
// Remote serial transceiver model on the far side of the serial lines
// Assumes the bench sets bit_clks and nbits before each frame
`timescale 1ns/1ns
module serial_far_end (
  // Clock
  input wire logic aclk,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  int bit_clks = 32;
  int nbits = 8;
  int got_n = 0;
  int low_n = 0;
  logic [8:0] got;

  // =====
  // Frame sender: start 0, data LSB first, stop 1, then idle high
  task automatic send(input logic [8:0] d);
    for (int i = -1; i <= nbits; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i == nbits) ? 1'b1 : d[i];
      repeat (bit_clks) @(posedge aclk);
    end
  endtask

  initial rxd = 1'b1;

  // =====
  // Frame receiver: times the start bit, samples each data bit mid-way
  always begin
    @(negedge txd);
    low_n = 0;
    got = '0;
    while (!txd) begin
      low_n++;
      @(posedge aclk);
      #1;
    end
    repeat (bit_clks / 2) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      got[i] = txd;
      repeat (bit_clks) @(posedge aclk);
    end
    got_n++;
  end
endmodule

//--- dv/serial_port_properties.sv
// Checker for the serial port top-level ports
// Assumes it is bound to the top module with every pin connected by name
`timescale 1ns/1ns
module serial_port_properties
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Serial pin and interrupt
  input tx_pin_s tx_pin,
  input wire logic serial_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ctl_wr_q;
  logic ar_q;

  // Remembers a control register write since reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_wr_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'hD0) begin
      ctl_wr_q <= 1'b1;
    end
  end

  assign ar_q = s_axi_arvalid && s_axi_arready;

  // =====
  // Bus timing and register contents
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (ar_q |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer late");
  a_unmapped_err: assert property (ar_q && (s_axi_araddr > 8'hD0 || s_axi_araddr[1:0] != 0)
    |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_reserved_zero: assert property (ar_q && s_axi_araddr == 8'hCC
    |-> ##2 s_axi_rdata[5] == 1'b0 && s_axi_rdata[2:0] == 3'h0) else $error("reserved bits");
  a_ctrl_reset: assert property (ar_q && s_axi_araddr == 8'hD0 && !ctl_wr_q
    |-> ##2 s_axi_rdata == 32'h0) else $error("control not zero");
  a_irq_quiet: assert property (!ctl_wr_q |-> !serial_irq)
    else $error("irq without enable");
  a_reset_quiet: assert property ($rose(aresetn) |-> tx_pin.txd_en && !serial_irq)
    else $error("reset state");
  a_idle_high: assert property (tx_pin.txd_en |-> tx_pin.txd)
    else $error("released pin low");

  // =====
  // Main scenarios
  c_irq: cover property ($rose(serial_irq));
  c_tx: cover property ($fell(tx_pin.txd));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

//--- dv/tb.sv
// Self-checking bench for the serial port
// Assumes the far-end model drives rxd and watches the pulled-up txd wire
`timescale 1ns/1ns
module tb;
  import serial_port_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } row_s;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_irq, rxd;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  tx_pin_s tx_pin;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  row_s rows[8] = '{'{1'b0, 8'hC0, 8'h00, 8'hC0, 2'h0}, '{1'b0, 8'hD0, 8'h00, 8'h00, 2'h0},
    '{1'b1, 8'hCC, 8'hFF, 8'h00, 2'h0}, '{1'b0, 8'hCC, 8'h00, 8'h58, 2'h0},
    '{1'b1, 8'hC8, 8'hA5, 8'h00, 2'h0}, '{1'b0, 8'hC8, 8'h00, 8'hA5, 2'h0},
    '{1'b0, 8'hE1, 8'h00, 8'h00, 2'h2}, '{1'b1, 8'hCC, 8'h50, 8'h00, 2'h0}};
  logic [7:0] rate_t[5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h08};
  int bit_t[5] = '{32, 96, 128, 416, 64};

  async_serial_port_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .tx_pin, .serial_irq);
  serial_far_end i_far (.aclk, .txd(tx_pin.txd_en ? 1'b1 : tx_pin.txd), .rxd);

  // =====
  // Checking, closing and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wait_got;
    for (int k = 0; k < 6000 && i_far.got_n == n; k++) @(posedge aclk);
    check("frame seen", i_far.got_n, n + 1);
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end

  // Main sequence: register table, transmit rates, interrupts, receive
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      if (!rows[i].w) check("read data", rd_v, {24'h0, rows[i].e});
      check("response", {30'h0, rsp}, {30'h0, rows[i].r});
    end
    i_far.nbits = 9;
    foreach (rate_t[i]) begin
      wr(8'hC8, rate_t[i]);
      wr(8'hD0, 8'h08);
      i_far.bit_clks = bit_t[i];
      n = i_far.got_n;
      rd(8'hC0);
      check("pin enable", {31'h0, tx_pin.txd_en}, 32'h0);
      wr(8'hC4, 8'h5B);
      wait_got();
      check("frame", {23'h0, i_far.got}, 32'h15B);
      check("bit time", i_far.low_n, bit_t[i]);
      // Disable and let the stop bit end, so no preamble is owed
      wr(8'hD0, 8'h00);
      wait (tx_pin.txd_en);
    end
    wr(8'hD0, 8'h88);
    repeat (3) @(posedge aclk);
    check("irq empty", {31'h0, serial_irq}, 32'h1);
    wr(8'hD0, 8'h48);
    n = i_far.got_n;
    rd(8'hC0);
    wr(8'hC4, 8'h5B);
    repeat (3) @(posedge aclk);
    check("irq busy", {31'h0, serial_irq}, 32'h0);
    wait_got();
    repeat (40) @(posedge aclk);
    check("irq done", {31'h0, serial_irq}, 32'h1);
    wr(8'hD0, 8'h00);
    repeat (3) @(posedge aclk);
    check("pin released", {31'h0, tx_pin.txd_en}, 32'h1);
    wr(8'hC8, 8'h01);
    wr(8'hD0, 8'h24);
    i_far.bit_clks = 64;
    i_far.send(9'h1C3);
    repeat (3) @(posedge aclk);
    check("irq rx", {31'h0, serial_irq}, 32'h1);
    rd(8'hCC);
    check("ninth bit", rd_v, 32'hD0);
    rd(8'hC0);
    rd(8'hC4);
    check("rx data", rd_v, 32'hC3);
    repeat (3) @(posedge aclk);
    check("irq cleared", {31'h0, serial_irq}, 32'h0);
    i_far.send(9'h055);
    repeat (3) @(posedge aclk);
    rd(8'hC4);
    rd(8'hC0);
    check("full kept", {31'h0, rd_v[5]}, 32'h1);
    wr(8'hD0, 8'h00);
    rd(8'hC0);
    check("rx flags off", {27'h0, rd_v[5:1]}, 32'h0);
    // Reset in mid-run with interrupts enabled and pending
    wr(8'hD0, 8'hC4);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'hD0);
    check("control reset", rd_v, 32'h0);
    check("irq reset", {31'h0, serial_irq}, 32'h0);
    close_out();
  end
endmodule

bind async_serial_port_control serial_port_properties i_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .tx_pin,
  .serial_irq);
